// ### design/cst_pkg.sv
package cst_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CST_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CST_ADDR_ADC_MAIN = 8'h04;
  localparam logic [7:0] CST_ADDR_ADC_AUX = 8'h08;
  localparam logic [7:0] CST_ADDR_DAC_DATA = 8'h0c;
  localparam logic [7:0] CST_ADDR_DIVIDERS = 8'h10;
  localparam logic [7:0] CST_ADDR_ADJUST = 8'h14;
  localparam logic [1:0] CST_RESP_OKAY = 2'h0;
  localparam logic [1:0] CST_RESP_SLVERR = 2'h2;
  localparam logic [1:0] CST_RESP_DECERR = 2'h3;

  // ****************************************
  // Control word fields
  // ****************************************
  localparam int CST_CTRL_W = 10;
  localparam int CST_BIT_HIGHPASS = 2;
  localparam int CST_BIT_LOOPBACK = 3;
  localparam int CST_BIT_AUX = 4;
  localparam int CST_BIT_SYNC = 5;
  localparam int CST_BIT_GAIN_LO = 6;
  localparam int CST_BIT_GAIN_HI = 7;
  localparam int CST_BIT_SINX = 9;
  localparam logic [9:0] CST_CTRL_RESET = 10'h2e4;

  // ****************************************
  // Serial word layout
  // ****************************************
  localparam int CST_WORD_W = 16;
  localparam int CST_SAMPLE_LSB = 2;
  localparam int CST_SAMPLE_W = 14;
  localparam logic [1:0] CST_TAG_PRIMARY_SEC = 2'h3;
  localparam logic [1:0] CST_SEC_COUNT_A = 2'h0;
  localparam logic [1:0] CST_SEC_ADJUST = 2'h1;
  localparam logic [1:0] CST_SEC_COUNT_B = 2'h2;
  localparam logic [1:0] CST_SEC_CONTROL = 2'h3;
  localparam int CST_TX_FIELD_LSB = 9;
  localparam int CST_RX_FIELD_LSB = 2;

  // ****************************************
  // Divider widths and reset counts
  // ****************************************
  localparam int CST_DIV_W = 7;
  localparam logic [6:0] CST_COUNT_A_RESET = 7'h12;
  localparam logic [6:0] CST_COUNT_B_RESET = 7'h24;
  localparam logic [6:0] CST_ADJUST_RESET = 7'h01;

  // ****************************************
  // Serial timing
  // ****************************************
  localparam int CST_CLOCK_HZ = 25000000;
  localparam int CST_SHIFT_DIV = 4;
  localparam int CST_GAP_SHIFTS = 4;
  localparam int CST_BYTE_BITS = 8;
endpackage : cst_pkg

// ### design/cst_frame_seq.sv
module cst_frame_seq
  import cst_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic shift_tick,
  input wire logic start,
  input wire logic byte_mode,
  // Frame pins and events
  output logic frame_sync_n_q,
  output logic end_of_data_n_q,
  output logic bit_tick,
  output logic loading,
  output logic done_q
);
  typedef enum logic [2:0] {IDLE, FIRST, GAP, SECOND, EOD} cst_seq_e;
  cst_seq_e state_q;
  logic [3:0] cnt_q;
  logic start_q;
  wire last_first = cnt_q == (byte_mode ? 4'(CST_BYTE_BITS - 1) : 4'(CST_WORD_W - 1));
  wire last_gap = cnt_q == 4'(CST_GAP_SHIFTS - 1);
  wire last_second = cnt_q == 4'(CST_BYTE_BITS - 1);

  assign bit_tick = shift_tick && (state_q == FIRST || state_q == SECOND);
  assign loading = shift_tick && state_q == IDLE && (start_q || start);

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= IDLE;
      cnt_q <= 4'h0;
      start_q <= 1'b0;
      frame_sync_n_q <= 1'b1;
      end_of_data_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        start_q <= 1'b1;
      end
      if (shift_tick) begin
        cnt_q <= cnt_q + 4'h1;
        unique case (state_q)
          IDLE: begin
            cnt_q <= 4'h0;
            if (start_q || start) begin
              start_q <= 1'b0;
              frame_sync_n_q <= 1'b0;
              state_q <= FIRST;
            end
          end
          FIRST: begin
            if (last_first) begin
              cnt_q <= 4'h0;
              frame_sync_n_q <= 1'b1;
              if (byte_mode) begin
                end_of_data_n_q <= 1'b0;
                state_q <= GAP;
              end else begin
                state_q <= EOD;
              end
            end
          end
          GAP: begin
            if (last_gap) begin
              cnt_q <= 4'h0;
              frame_sync_n_q <= 1'b0;
              state_q <= SECOND;
            end
          end
          SECOND: begin
            if (last_second) begin
              end_of_data_n_q <= 1'b1;
              frame_sync_n_q <= 1'b1;
              done_q <= 1'b1;
              state_q <= IDLE;
            end
          end
          EOD: begin
            if (end_of_data_n_q) begin
              end_of_data_n_q <= 1'b0;
            end else begin
              end_of_data_n_q <= 1'b1;
              done_q <= 1'b1;
              state_q <= IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : cst_frame_seq

// ### design/cst_codec_ctrl.sv
// Overview of operation
// - DAC strobe divides transmit filter clock.
// - Asynchronous mode: independent clocks and rates.
// - Synchronous mode: transmit filter clock drives both.
// - Synchronous mode: ADC timing equals DAC timing.
// - Control bit inserts or bypasses correction filter.
// - Four serial modes: sync bit times pin.
// - Reset pulse initialises every internal register.
// - Loopback returns DAC data as ADC data.
// - Loopback bit arrives through the serial control word.
// - Sample occupies word bits 15 down to 2.
// - Input-select one picks auxiliary input pair.
// - ADC bits leave on serial output.
// - DAC and control bits captured from serial input.
// - Word mode: end-of-data pulse after sixteen bits.
// - Byte mode: end-of-data low between bytes.
// - No receive frame after secondary word.
// - Shift clock is master clock over four.
// - Reset control and adjust registers to values.
// - Word mode: sync low, word, high, strobe.
// - Byte mode: four-shift positive sync pulse between bytes.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
module cst_codec_ctrl
  import cst_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial port pins
  input wire logic word_byte_sel,
  input wire logic dac_serial_in,
  output logic adc_serial_out,
  output logic shift_clk,
  output logic tx_frame_sync_n,
  output logic rx_frame_sync_n,
  output logic tx_end_of_data_n,
  output logic rx_end_of_data_n,
  // Analog path selection and conversion timing
  output logic loopback_en,
  output logic aux_input_sel,
  output logic sinx_filter_in,
  output logic highpass_en,
  output logic [1:0] input_gain,
  output logic tx_filter_tick,
  output logic rx_filter_tick,
  output logic dac_convert,
  output logic adc_convert
);
  // ****************************************
  // Pin synchronisers and shift clock
  // ****************************************
  logic [1:0] dx_sync_q;
  logic [1:0] wb_sync_q;
  logic [1:0] phase_q;
  logic shift_clk_q;
  wire shift_tick = phase_q == 2'(CST_SHIFT_DIV - 1);
  wire dx_bit = dx_sync_q[1];
  wire byte_mode = !wb_sync_q[1];

  always_ff @(posedge clock) begin
    if (reset) begin
      dx_sync_q <= 2'h0;
      wb_sync_q <= 2'h3;
      phase_q <= 2'h0;
      shift_clk_q <= 1'b0;
    end else begin
      dx_sync_q <= {dx_sync_q[0], dac_serial_in};
      wb_sync_q <= {wb_sync_q[0], word_byte_sel};
      phase_q <= phase_q + 2'h1;
      shift_clk_q <= phase_q[1];
    end
  end

  // ****************************************
  // Control, count and adjust registers
  // ****************************************
  logic [CST_CTRL_W-1:0] ctrl_q;
  logic [CST_DIV_W-1:0] count_q [4];
  logic [CST_DIV_W-1:0] adj_q [2];
  logic [1:0] adj_pend_q;
  logic [CST_SAMPLE_W-1:0] dac_data_q;
  wire sync_mode = ctrl_q[CST_BIT_SYNC];

  // ****************************************
  // Conversion timing dividers
  // ****************************************
  // Index 0 is transmit A, 1 transmit B, 2 receive A, 3 receive B.
  logic [CST_DIV_W-1:0] div_cnt_q [4];
  logic [3:0] tick_q;
  logic [3:0] div_en;
  logic [CST_DIV_W:0] div_period [4];
  assign div_en[0] = 1'b1;
  assign div_en[1] = tick_q[0];
  assign div_en[2] = !sync_mode;
  assign div_en[3] = sync_mode ? tick_q[0] : tick_q[2];

  for (genvar i = 0; i < 4; i++) begin : g_div
    if (i % 2 == 0) begin : g_adj
      assign div_period[i] = {1'b0, count_q[i]} +
        (adj_pend_q[i/2] ? {1'b0, adj_q[i/2]} : (CST_DIV_W + 1)'(0));
    end else begin : g_plain
      assign div_period[i] = {1'b0, count_q[i]};
    end
    wire last = {1'b0, div_cnt_q[i]} + (CST_DIV_W + 1)'(1) >= div_period[i];
    always_ff @(posedge clock) begin
      if (reset) begin
        div_cnt_q[i] <= '0;
        tick_q[i] <= 1'b0;
      end else begin
        tick_q[i] <= div_en[i] && last;
        if (div_en[i]) begin
          div_cnt_q[i] <= last ? '0 : div_cnt_q[i] + (CST_DIV_W)'(1);
        end
      end
    end
  end

  wire tx_filter = tick_q[0];
  wire rx_filter = sync_mode ? tick_q[0] : tick_q[2];
  wire tx_conv = tick_q[1];
  wire rx_conv = sync_mode ? tick_q[1] : tick_q[3];

  // ****************************************
  // Frame sequencers
  // ****************************************
  logic sec_start_q;
  logic sec_phase_q;
  logic tx_bit;
  logic tx_done;
  logic rx_bit;
  logic rx_load;
  wire tx_start = tx_conv || sec_start_q;
  wire rx_start = rx_conv;

  cst_frame_seq u_tx_seq (
    .clock(clock),
    .reset(reset),
    .shift_tick(shift_tick),
    .start(tx_start),
    .byte_mode(byte_mode),
    .frame_sync_n_q(tx_frame_sync_n),
    .end_of_data_n_q(tx_end_of_data_n),
    .bit_tick(tx_bit),
    .loading(),
    .done_q(tx_done)
  );

  cst_frame_seq u_rx_seq (
    .clock(clock),
    .reset(reset),
    .shift_tick(shift_tick),
    .start(rx_start),
    .byte_mode(byte_mode),
    .frame_sync_n_q(rx_frame_sync_n),
    .end_of_data_n_q(rx_end_of_data_n),
    .bit_tick(rx_bit),
    .loading(rx_load),
    .done_q()
  );

  // ****************************************
  // Serial data paths
  // ****************************************
  logic [CST_WORD_W-1:0] tx_shift_q;
  logic [CST_WORD_W-1:0] rx_shift_q;
  logic [CST_WORD_W-1:0] adc_main_q;
  logic [CST_WORD_W-1:0] adc_aux_q;
  wire [CST_WORD_W-1:0] analog_word = ctrl_q[CST_BIT_AUX] ? adc_aux_q : adc_main_q;
  wire [CST_SAMPLE_W-1:0] adc_sample = ctrl_q[CST_BIT_LOOPBACK] ? dac_data_q
    : analog_word[CST_WORD_W-1:CST_SAMPLE_LSB];
  wire [CST_WORD_W-1:0] adc_word = {adc_sample, 2'h0};
  wire [1:0] tag = tx_shift_q[1:0];
  wire [CST_DIV_W-1:0] tx_field = tx_shift_q[CST_TX_FIELD_LSB +: CST_DIV_W];
  wire [CST_DIV_W-1:0] rx_field = tx_shift_q[CST_RX_FIELD_LSB +: CST_DIV_W];
  logic adc_out_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_shift_q <= '0;
      rx_shift_q <= '0;
      adc_out_q <= 1'b0;
    end else begin
      if (tx_bit) begin
        tx_shift_q <= {tx_shift_q[CST_WORD_W-2:0], dx_bit};
      end
      if (rx_load) begin
        rx_shift_q <= adc_word;
        adc_out_q <= adc_word[CST_WORD_W-1];
      end else if (rx_bit) begin
        rx_shift_q <= {rx_shift_q[CST_WORD_W-2:0], 1'b0};
        adc_out_q <= rx_shift_q[CST_WORD_W-2];
      end
    end
  end

  // Secondary words carry no sample, so the receive side never frames them.
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q <= CST_CTRL_RESET;
      count_q[0] <= CST_COUNT_A_RESET;
      count_q[1] <= CST_COUNT_B_RESET;
      count_q[2] <= CST_COUNT_A_RESET;
      count_q[3] <= CST_COUNT_B_RESET;
      adj_q[0] <= CST_ADJUST_RESET;
      adj_q[1] <= CST_ADJUST_RESET;
      adj_pend_q <= 2'h0;
      dac_data_q <= '0;
      sec_start_q <= 1'b0;
      sec_phase_q <= 1'b0;
    end else begin
      sec_start_q <= 1'b0;
      if (tick_q[0] && adj_pend_q[0]) begin
        adj_pend_q[0] <= 1'b0;
      end
      if (tick_q[2] && adj_pend_q[1]) begin
        adj_pend_q[1] <= 1'b0;
      end
      if (tx_done && !sec_phase_q) begin
        dac_data_q <= tx_shift_q[CST_WORD_W-1:CST_SAMPLE_LSB];
        if (tag == CST_TAG_PRIMARY_SEC) begin
          sec_start_q <= 1'b1;
          sec_phase_q <= 1'b1;
        end
      end else if (tx_done) begin
        sec_phase_q <= 1'b0;
        unique case (tag)
          CST_SEC_COUNT_A: begin
            count_q[0] <= tx_field;
            count_q[2] <= rx_field;
          end
          CST_SEC_ADJUST: begin
            adj_q[0] <= tx_field;
            adj_q[1] <= rx_field;
            adj_pend_q <= 2'h3;
          end
          CST_SEC_COUNT_B: begin
            count_q[1] <= tx_field;
            count_q[3] <= rx_field;
          end
          CST_SEC_CONTROL: begin
            ctrl_q <= tx_shift_q[CST_CTRL_W-1:0];
          end
        endcase
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      loopback_en <= 1'b0;
      aux_input_sel <= 1'b0;
      sinx_filter_in <= 1'b0;
      highpass_en <= 1'b0;
      input_gain <= 2'h0;
      tx_filter_tick <= 1'b0;
      rx_filter_tick <= 1'b0;
      dac_convert <= 1'b0;
      adc_convert <= 1'b0;
      adc_serial_out <= 1'b0;
      shift_clk <= 1'b0;
    end else begin
      loopback_en <= ctrl_q[CST_BIT_LOOPBACK];
      aux_input_sel <= ctrl_q[CST_BIT_AUX];
      sinx_filter_in <= ctrl_q[CST_BIT_SINX];
      highpass_en <= ctrl_q[CST_BIT_HIGHPASS];
      input_gain <= ctrl_q[CST_BIT_GAIN_HI:CST_BIT_GAIN_LO];
      tx_filter_tick <= tx_filter;
      rx_filter_tick <= rx_filter;
      dac_convert <= tx_conv;
      adc_convert <= rx_conv;
      adc_serial_out <= adc_out_q;
      shift_clk <= shift_clk_q;
    end
  end

  // ****************************************
  // AXI4-Lite register access
  // ****************************************
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_main = awaddr_q == CST_ADDR_ADC_MAIN;
  wire wr_aux = awaddr_q == CST_ADDR_ADC_AUX;
  wire wr_ro = awaddr_q == CST_ADDR_CTRL || awaddr_q == CST_ADDR_DAC_DATA
    || awaddr_q == CST_ADDR_DIVIDERS || awaddr_q == CST_ADDR_ADJUST;
  wire [1:0] wr_resp = (wr_main || wr_aux) ? CST_RESP_OKAY
    : (wr_ro ? CST_RESP_SLVERR : CST_RESP_DECERR);
  wire [15:0] wr_merge_main = {wstrb_q[1] ? wdata_q[15:8] : adc_main_q[15:8],
    wstrb_q[0] ? wdata_q[7:0] : adc_main_q[7:0]};
  wire [15:0] wr_merge_aux = {wstrb_q[1] ? wdata_q[15:8] : adc_aux_q[15:8],
    wstrb_q[0] ? wdata_q[7:0] : adc_aux_q[7:0]};
  wire [31:0] rd_dividers = {count_q[3], 1'b0, count_q[2], 1'b0,
    count_q[1], 1'b0, count_q[0], 1'b0};
  wire [31:0] rd_adjust = {12'h0, adj_pend_q, 2'h0, 1'b0, adj_q[1], 1'b0, adj_q[0]};
  wire [31:0] rd_status = {14'h0, sec_phase_q, byte_mode, 6'h0, ctrl_q};
  wire rd_hit = s_axi_araddr == CST_ADDR_CTRL || s_axi_araddr == CST_ADDR_ADC_MAIN
    || s_axi_araddr == CST_ADDR_ADC_AUX || s_axi_araddr == CST_ADDR_DAC_DATA
    || s_axi_araddr == CST_ADDR_DIVIDERS || s_axi_araddr == CST_ADDR_ADJUST;
  wire [31:0] rd_data =
    s_axi_araddr == CST_ADDR_CTRL ? rd_status
    : s_axi_araddr == CST_ADDR_ADC_MAIN ? {16'h0, adc_main_q}
    : s_axi_araddr == CST_ADDR_ADC_AUX ? {16'h0, adc_aux_q}
    : s_axi_araddr == CST_ADDR_DAC_DATA ? {16'h0, dac_data_q, 2'h0}
    : s_axi_araddr == CST_ADDR_DIVIDERS ? rd_dividers
    : s_axi_araddr == CST_ADDR_ADJUST ? rd_adjust : 32'h0;

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CST_RESP_OKAY;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      adc_main_q <= 16'h0;
      adc_aux_q <= 16'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
        if (wr_main) begin
          adc_main_q <= wr_merge_main;
        end
        if (wr_aux) begin
          adc_aux_q <= wr_merge_aux;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= CST_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? CST_RESP_OKAY : CST_RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : cst_codec_ctrl

// ### testbench/cst_codec_ctrl_assertions.sv
module cst_assert (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Serial pins
  input wire logic word_byte_sel,
  input wire logic shift_clk,
  input wire logic tx_frame_sync_n,
  input wire logic rx_frame_sync_n,
  input wire logic rx_end_of_data_n,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Path selection
  input wire logic sinx_filter_in,
  input wire logic highpass_en,
  input wire logic [1:0] input_gain,
  input wire logic loopback_en,
  input wire logic aux_input_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // *********
  // Helpers
  // *********
  logic [7:0] low_cnt_q;
  always_ff @(posedge clock) begin
    if (reset || tx_frame_sync_n) begin
      low_cnt_q <= 8'h00;
    end else begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  sequence s_eod_pulse;
    (!rx_end_of_data_n) [*4] ##1 rx_end_of_data_n;
  endsequence
  sequence s_gap;
    rx_frame_sync_n [*8] ##1 rx_frame_sync_n [*8] ##1 !rx_frame_sync_n;
  endsequence
  // *********
  // Properties
  // *********
  property p_shift;
    $rose(shift_clk) |-> ##1 shift_clk ##1 !shift_clk [*2] ##1 shift_clk;
  endproperty
  property p_seg_len;
    $rose(tx_frame_sync_n) |-> low_cnt_q == (word_byte_sel ? 8'h40 : 8'h20);
  endproperty
  property p_eod_pulse;
    word_byte_sel && $fell(rx_end_of_data_n) |-> rx_frame_sync_n throughout s_eod_pulse;
  endproperty
  property p_gap;
    !word_byte_sel && $rose(rx_frame_sync_n) && !rx_end_of_data_n |->
      !rx_end_of_data_n throughout s_gap;
  endproperty
  property p_rx_with_tx;
    $fell(rx_frame_sync_n) |-> $fell(tx_frame_sync_n);
  endproperty
  property p_reset_ctrl;
    $fell(reset) |-> ##[1:2] (sinx_filter_in && highpass_en && input_gain == 2'h3 &&
      !loopback_en && !aux_input_sel);
  endproperty
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_shift: assert property (p_shift)
    else $error("bad shift clock");
  a_seg_len: assert property (p_seg_len)
    else $error("bad frame length");
  a_eod_pulse: assert property (p_eod_pulse)
    else $error("bad word eod pulse");
  a_gap: assert property (p_gap)
    else $error("bad byte gap");
  a_rx_with_tx: assert property (p_rx_with_tx)
    else $error("lone receive frame");
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("bad reset selection");
  a_rd_lat: assert property (p_rd_lat)
    else $error("late read");
  a_b_once: assert property (p_b_once)
    else $error("repeated bresp");
endmodule : cst_assert

bind cst_codec_ctrl cst_assert u_chk (
  .clock, .reset, .word_byte_sel, .shift_clk, .tx_frame_sync_n, .rx_frame_sync_n,
  .rx_end_of_data_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready, .sinx_filter_in, .highpass_en, .input_gain, .loopback_en, .aux_input_sel
);

// ### testbench/cst_dsp_model.sv
module cst_dsp_model (
  // Clock
  input wire logic clock,
  // Codec serial pins
  input wire logic shift_clk,
  input wire logic tx_frame_sync_n,
  input wire logic rx_frame_sync_n,
  input wire logic tx_end_of_data_n,
  input wire logic adc_serial_out,
  output logic dac_serial_in,
  // Words to and from the bench
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sc_q = 1'h0;
  logic last_q = 1'h0;
  logic [3:0] bit_q = 4'h0;
  assign dac_serial_in = tx_frame_sync_n ? !last_q : tx_word[4'hf - bit_q];
  always_ff @(posedge clock) begin
    sc_q <= shift_clk;
    last_q <= (dac_serial_in === 1'h1);
    if (tx_frame_sync_n && tx_end_of_data_n) begin
      bit_q <= 4'h0;
    end else if (!tx_frame_sync_n && sc_q && !shift_clk) begin
      bit_q <= bit_q + 4'h1;
    end
    if (!rx_frame_sync_n && sc_q && !shift_clk) begin
      rx_word_q <= {rx_word_q[14:0], adc_serial_out};
    end
  end
endmodule : cst_dsp_model

// ### testbench/tb_top.sv
module tb_top
  import cst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, word_byte_sel = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, input_gain;
  logic dac_serial_in, adc_serial_out, shift_clk, tx_frame_sync_n, rx_frame_sync_n;
  logic tx_end_of_data_n, rx_end_of_data_n, loopback_en, aux_input_sel, sinx_filter_in;
  logic highpass_en, tx_filter_tick, rx_filter_tick, dac_convert, adc_convert;
  logic [15:0] tx_word = 16'h0, rx_word;
  logic rx_fs_q = 1'h1;
  int error_cnt = 0, checks = 0, cyc = 0, rx_falls = 0, sync_err = 0;

  cst_codec_ctrl uut (
    .clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .word_byte_sel, .dac_serial_in, .adc_serial_out,
    .shift_clk, .tx_frame_sync_n, .rx_frame_sync_n, .tx_end_of_data_n, .rx_end_of_data_n,
    .loopback_en, .aux_input_sel, .sinx_filter_in, .highpass_en, .input_gain,
    .tx_filter_tick, .rx_filter_tick, .dac_convert, .adc_convert
  );
  cst_dsp_model u_dsp (
    .clock, .shift_clk, .tx_frame_sync_n, .rx_frame_sync_n, .tx_end_of_data_n,
    .adc_serial_out, .dac_serial_in, .tx_word, .rx_word_q(rx_word)
  );

  initial forever #20 clock = ~clock;

  // *********
  // Monitor and helpers
  // *********
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rx_fs_q <= rx_frame_sync_n;
    if (rx_fs_q && !rx_frame_sync_n)
      rx_falls++;
    if (!reset && (adc_convert !== dac_convert || rx_filter_tick !== tx_filter_tick))
      sync_err++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok = 1'h0, w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'h1 && !aw_ok) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready === 1'h1 && !w_ok) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end while (!(aw_ok && w_ok));
    while (s_axi_bvalid !== 1'h1) @(posedge clock);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
    @(posedge clock);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clock); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge clock);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata & m, e, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
    @(posedge clock);
  endtask : axi_rd

  task automatic frame(input logic [15:0] w1, input logic [15:0] w2);
    while (dac_convert !== 1'h1) @(posedge clock);
    tx_word <= w1;
    while (tx_frame_sync_n !== 1'h0) @(posedge clock);
    while (tx_frame_sync_n !== 1'h1) @(posedge clock);
    tx_word <= w2;
    while (tx_end_of_data_n !== 1'h0) @(posedge clock);
    while (tx_end_of_data_n !== 1'h1) @(posedge clock);
  endtask : frame

  // *********
  // Scenarios
  // *********
  task automatic t_reset();
    axi_rd(CST_ADDR_CTRL, 32'h0003_03ff, {22'h0, CST_CTRL_RESET}, CST_RESP_OKAY);
    axi_rd(CST_ADDR_DIVIDERS, 32'hffff_ffff, {CST_COUNT_B_RESET, 1'h0, CST_COUNT_A_RESET,
      1'h0, CST_COUNT_B_RESET, 1'h0, CST_COUNT_A_RESET, 1'h0}, CST_RESP_OKAY);
    axi_rd(CST_ADDR_ADJUST, 32'h000f_7f7f, {17'h0, CST_ADJUST_RESET, 1'h0,
      CST_ADJUST_RESET}, CST_RESP_OKAY);
    axi_rd(8'h20, 32'hffff_ffff, 32'h0, CST_RESP_DECERR);
    axi_wr(CST_ADDR_CTRL, 32'h0, CST_RESP_SLVERR);
    axi_wr(CST_ADDR_ADC_AUX, 32'h0000_9876, CST_RESP_OKAY);
    axi_rd(CST_ADDR_ADC_AUX, 32'h0000_ffff, 32'h0000_9876, CST_RESP_OKAY);
    chk(32'({sinx_filter_in, highpass_en, input_gain, loopback_en, aux_input_sel}),
      32'h3c, "reset selection");
  endtask : t_reset

  task automatic t_rate();
    int n = 0, t = 0;
    while (dac_convert !== 1'h1) @(posedge clock);
    do begin
      @(posedge clock);
      n++;
      if (tx_filter_tick === 1'h1)
        t++;
    end while (dac_convert !== 1'h1);
    chk(32'(n), 32'(CST_COUNT_A_RESET) * 32'(CST_COUNT_B_RESET), "period");
    chk(32'(t), 32'(CST_COUNT_B_RESET), "filter ticks");
  endtask : t_rate

  task automatic t_word();
    axi_wr(CST_ADDR_ADC_MAIN, 32'h0000_a5a4, CST_RESP_OKAY);
    frame(16'h1238, 16'h1238);
    chk(32'(rx_word & 16'hfffc), 32'h0000_a5a4, "adc word");
    axi_rd(CST_ADDR_DAC_DATA, 32'hffff_ffff, 32'h0000_1238, CST_RESP_OKAY);
  endtask : t_word

  task automatic t_ctrl();
    logic [9:0] c = CST_CTRL_RESET | 10'h018;
    int n0 = rx_falls;
    frame(16'h0003, {6'h0, c[9:2], CST_SEC_CONTROL});
    while (tx_end_of_data_n !== 1'h0) @(posedge clock);
    while (tx_end_of_data_n !== 1'h1) @(posedge clock);
    chk(32'(rx_falls - n0), 32'h1, "secondary frame");
    repeat (4) @(posedge clock);
    chk(32'({loopback_en, aux_input_sel}), 32'h3, "loop select");
    axi_rd(CST_ADDR_CTRL, 32'h0000_03fc, {22'h0, c & 10'h3fc}, CST_RESP_OKAY);
  endtask : t_ctrl

  task automatic t_byte();
    frame(16'h4c30, 16'h4c30);
    word_byte_sel <= 1'h0;
    repeat (4) @(posedge clock);
    axi_rd(CST_ADDR_CTRL, 32'h0001_0000, 32'h0001_0000, CST_RESP_OKAY);
    frame(16'h5a5c, 16'h5a5c);
    chk(32'(rx_word & 16'hfffc), 32'h0000_4c30, "loopback word");
    frame(16'h0000, 16'h0000);
    chk(32'(rx_word & 16'hfffc), 32'h0000_5a5c, "byte word");
  endtask : t_byte

  task automatic close_out();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    t_reset();
    t_rate();
    t_word();
    t_ctrl();
    t_byte();
    chk(32'(sync_err), 32'h0, "rx timing");
    close_out();
  end
endmodule : tb_top
